// ---- hw/screen_block_cursor_config.v ----
// screen block and cursor configuration registers behind an axi4-lite slave
`timescale 1ns/1ps
`include "screen_cfg_consts.vh"
module screen_block_cursor_config (
    mclk,
    nrst,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    frame_start,
    host_mem_access,
    block1_line_count,
    block2_start_addr,
    block3_start_addr,
    block4_start_addr,
    block2_line_count,
    block3_line_count,
    block4_line_count,
    block1_blank_lines,
    block2_blank_lines,
    cursor_width,
    cursor_height,
    cursor_shape_select,
    cursor_attr,
    cursor_visible,
    cursor_dir,
    cmd_valid,
    cmd_byte,
    cmd_param0,
    cmd_param1
);
    input  wire        mclk;
    input  wire        nrst;
    input  wire [15:0] s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [15:0] s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        frame_start;
    input  wire        host_mem_access;
    input  wire [7:0]  block1_line_count;
    output wire [14:0] block2_start_addr;
    output wire [14:0] block3_start_addr;
    output wire [14:0] block4_start_addr;
    output reg  [7:0]  block2_line_count;
    output reg  [7:0]  block3_line_count;
    output reg  [7:0]  block4_line_count;
    output reg  [7:0]  block1_blank_lines;
    output reg  [7:0]  block2_blank_lines;
    output reg  [3:0]  cursor_width;
    output reg  [3:0]  cursor_height;
    output reg         cursor_shape_select;
    output reg  [1:0]  cursor_attr;
    output reg         cursor_visible;
    output reg  [1:0]  cursor_dir;
    output reg         cmd_valid;
    output reg  [7:0]  cmd_byte;
    output reg  [7:0]  cmd_param0;
    output reg  [7:0]  cmd_param1;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // offsets are all word aligned, so the byte address is index * 4
    function [15:0] idx_of;
        input [15:0] byte_addr;
        begin
            idx_of = {2'b10, byte_addr[15:2]};
        end
    endfunction

    function known_idx;
        input [15:0] idx;
        begin
            known_idx = 1'b0;
            if ((idx >= `IDX_B2_START_LOW && idx <= `IDX_CURSOR_DIR) ||
                (idx >= `IDX_UNIT_CTRL && idx <= `IDX_CMD))
                known_idx = 1'b1;
        end
    endfunction

    reg        aw_full_r;
    reg        w_full_r;
    reg [15:0] aw_idx_r;
    reg [7:0]  w_byte_r;
    reg        w_lane0_r;

    assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire        wr_go  = aw_full_r & w_full_r & ~s_axi_bvalid;
    wire        wr_ok  = wr_go & known_idx(aw_idx_r);
    wire        wr_en  = wr_ok & w_lane0_r;
    wire [15:0] rd_idx = idx_of(s_axi_araddr);

    always @(posedge mclk) begin
        if (!nrst) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            aw_idx_r     <= 16'h0000;
            w_byte_r     <= `RST_BYTE;
            w_lane0_r    <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_idx_r  <= idx_of(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r  <= 1'b1;
                w_byte_r  <= s_axi_wdata[7:0];
                w_lane0_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_idx(aw_idx_r) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wr_hit_b2_low   = wr_en && aw_idx_r == `IDX_B2_START_LOW;
    wire wr_hit_b2_high  = wr_en && aw_idx_r == `IDX_B2_START_HIGH;
    wire wr_hit_b3_low   = wr_en && aw_idx_r == `IDX_B3_START_LOW;
    wire wr_hit_b3_high  = wr_en && aw_idx_r == `IDX_B3_START_HIGH;
    wire wr_hit_b4_low   = wr_en && aw_idx_r == `IDX_B4_START_LOW;
    wire wr_hit_b4_high  = wr_en && aw_idx_r == `IDX_B4_START_HIGH;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [7:0] width_ctrl_r;
    reg  [7:0] height_ctrl_r;
    reg  [7:0] dir_r;
    reg  [7:0] unit_ctrl_r;
    reg  [7:0] frame_line_count_r;
    reg  [7:0] b2_lines_r;
    wire [7:0] b2_low;
    wire [7:0] b2_high;
    wire [7:0] b3_low;
    wire [7:0] b3_high;
    wire [7:0] b4_low;
    wire [7:0] b4_high;
    wire       scroll_latch = unit_ctrl_r[`BIT_SCROLL_LATCH];
    wire       dual_panel   = unit_ctrl_r[`BIT_DUAL_PANEL];

    start_addr_stage u_b2 (
        .mclk         (mclk),
        .nrst         (nrst),
        .wr_low       (wr_hit_b2_low),
        .wr_high      (wr_hit_b2_high),
        .wdata        (w_byte_r),
        .scroll_latch (scroll_latch),
        .low_r        (b2_low),
        .high_r       (b2_high),
        .disp_addr    (block2_start_addr)
    );

    start_addr_stage u_b3 (
        .mclk         (mclk),
        .nrst         (nrst),
        .wr_low       (wr_hit_b3_low),
        .wr_high      (wr_hit_b3_high),
        .wdata        (w_byte_r),
        .scroll_latch (scroll_latch),
        .low_r        (b3_low),
        .high_r       (b3_high),
        .disp_addr    (block3_start_addr)
    );

    start_addr_stage u_b4 (
        .mclk         (mclk),
        .nrst         (nrst),
        .wr_low       (wr_hit_b4_low),
        .wr_high      (wr_hit_b4_high),
        .wdata        (w_byte_r),
        .scroll_latch (scroll_latch),
        .low_r        (b4_low),
        .high_r       (b4_high),
        .disp_addr    (block4_start_addr)
    );

    // host memory access sets an off attribute to steady unless auto-disable is set; the set wins over a same-cycle write
    wire auto_on = host_mem_access & ~width_ctrl_r[`BIT_AUTO_DIS];

    always @(posedge mclk) begin
        if (!nrst) begin
            width_ctrl_r       <= `RST_BYTE;
            height_ctrl_r      <= `RST_BYTE;
            dir_r              <= `RST_BYTE;
            unit_ctrl_r        <= `RST_BYTE;
            frame_line_count_r <= `RST_BYTE;
            b2_lines_r         <= `RST_BYTE;
            cursor_attr        <= `RST_ATTR;
            cmd_valid          <= 1'b0;
            cmd_byte           <= `RST_BYTE;
            cmd_param0         <= `RST_BYTE;
            cmd_param1         <= `RST_BYTE;
        end else begin
            cmd_valid <= 1'b0;
            if (wr_en) begin
                case (aw_idx_r)
                    `IDX_B2_LINE_COUNT: b2_lines_r <= w_byte_r;
                    `IDX_CURSOR_WIDTH:  width_ctrl_r <= w_byte_r & 8'h8F;
                    `IDX_CURSOR_HEIGHT: height_ctrl_r <= w_byte_r & 8'h8F;
                    `IDX_CURSOR_DIR:    dir_r <= w_byte_r & 8'h03;
                    `IDX_UNIT_CTRL:     unit_ctrl_r <= w_byte_r & 8'h19;
                    `IDX_FRAME_CFG:     frame_line_count_r <= w_byte_r;
                    `IDX_UNIT_STATUS:   cursor_attr <= w_byte_r[1:0];
                    `IDX_CMD: begin
                        if (w_byte_r == `CMD_CURSOR_FORM) begin
                            cmd_valid  <= 1'b1;
                            cmd_byte   <= w_byte_r;
                            cmd_param0 <= width_ctrl_r;
                            cmd_param1 <= height_ctrl_r;
                        end else if (w_byte_r[7:2] == `CMD_DIR_BASE >> 2) begin
                            cmd_valid  <= 1'b1;
                            cmd_byte   <= w_byte_r;
                            cmd_param0 <= {6'h00, w_byte_r[1:0]};
                            cmd_param1 <= `RST_BYTE;
                            dir_r      <= {6'h00, w_byte_r[1:0]};
                        end
                    end
                    default: ;
                endcase
            end
            if (auto_on && cursor_attr == `ATTR_OFF)
                cursor_attr <= `ATTR_STEADY;
        end
    end

    // ----------------------------------------------------------------
    // derived line counts and cursor outputs
    // ----------------------------------------------------------------
    wire [8:0] half_frame = ({1'b0, frame_line_count_r} + 9'd1) >> 1;
    wire [7:0] b1_min_b2  = (block1_line_count < b2_lines_r) ? block1_line_count : b2_lines_r;

    // flash phase over frames; on for the first 70 percent
    reg  [5:0] frame_cnt_r;
    wire [6:0] period  = (cursor_attr == `ATTR_FLASH32) ? 7'd32 : 7'd64;
    wire [6:0] phase   = (cursor_attr == `ATTR_FLASH32) ? {2'b00, frame_cnt_r[4:0]}
                                                         : {1'b0, frame_cnt_r};
    wire [13:0] on_lim = period * `FLASH_ON_PCT;
    wire [13:0] ph_pct = phase * `FLASH_PCT_FULL;

    always @(posedge mclk) begin
        if (!nrst) begin
            frame_cnt_r         <= 6'h00;
            block2_line_count   <= `RST_BYTE;
            block3_line_count   <= `RST_BYTE;
            block4_line_count   <= `RST_BYTE;
            block1_blank_lines  <= `RST_BYTE;
            block2_blank_lines  <= `RST_BYTE;
            cursor_width        <= 4'h0;
            cursor_height       <= 4'h0;
            cursor_shape_select <= 1'b0;
            cursor_visible      <= 1'b0;
            cursor_dir          <= `DIR_RIGHT;
        end else begin
            if (frame_start)
                frame_cnt_r <= frame_cnt_r + 6'h01;
            block2_line_count <= b2_lines_r;
            block3_line_count <= b1_min_b2;
            block4_line_count <= frame_line_count_r;
            // counts are minus-one encoded, so a block covers count+1 lines
            if (dual_panel && ({1'b0, block1_line_count} + 9'd1) < half_frame)
                block1_blank_lines <= half_frame[7:0] - block1_line_count - 8'd1;
            else
                block1_blank_lines <= `RST_BYTE;
            if (dual_panel && ({1'b0, b2_lines_r} + 9'd1) < half_frame)
                block2_blank_lines <= half_frame[7:0] - b2_lines_r - 8'd1;
            else
                block2_blank_lines <= `RST_BYTE;
            cursor_width        <= width_ctrl_r[3:0];
            cursor_height       <= height_ctrl_r[3:0];
            cursor_shape_select <= height_ctrl_r[`BIT_SHAPE];
            cursor_dir          <= dir_r[1:0];
            case (cursor_attr)
                `ATTR_OFF:    cursor_visible <= 1'b0;
                `ATTR_STEADY: cursor_visible <= 1'b1;
                default:      cursor_visible <= (ph_pct < on_lim);
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (rd_idx)
            `IDX_B2_START_LOW:  rd_byte = b2_low;
            `IDX_B2_START_HIGH: rd_byte = b2_high;
            `IDX_B2_LINE_COUNT: rd_byte = b2_lines_r;
            `IDX_B3_START_LOW:  rd_byte = b3_low;
            `IDX_B3_START_HIGH: rd_byte = b3_high;
            `IDX_B4_START_LOW:  rd_byte = b4_low;
            `IDX_B4_START_HIGH: rd_byte = b4_high;
            `IDX_CURSOR_WIDTH:  rd_byte = width_ctrl_r;
            `IDX_CURSOR_HEIGHT: rd_byte = height_ctrl_r;
            `IDX_CURSOR_DIR:    rd_byte = dir_r;
            `IDX_UNIT_CTRL:     rd_byte = unit_ctrl_r;
            `IDX_UNIT_STATUS:   rd_byte = {5'h00, cursor_visible, cursor_attr};
            `IDX_FRAME_CFG:     rd_byte = frame_line_count_r;
            `IDX_CMD:           rd_byte = cmd_byte;
            default:            rd_byte = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= known_idx(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // screen_block_cursor_config

// ---- hw/screen_cfg_consts.vh ----
// constants for the screen block config
`ifndef SCREEN_CFG_CONSTS_VH
`define SCREEN_CFG_CONSTS_VH
// register indices
`define IDX_B2_START_LOW    16'h800E
`define IDX_B2_START_HIGH   16'h800F
`define IDX_B2_LINE_COUNT   16'h8010
`define IDX_B3_START_LOW    16'h8011
`define IDX_B3_START_HIGH   16'h8012
`define IDX_B4_START_LOW    16'h8013
`define IDX_B4_START_HIGH   16'h8014
`define IDX_CURSOR_WIDTH    16'h8015
`define IDX_CURSOR_HEIGHT   16'h8016
`define IDX_CURSOR_DIR      16'h8017
// own registers for loose bits, status and commands
`define IDX_UNIT_CTRL       16'h8100
`define IDX_UNIT_STATUS     16'h8101
`define IDX_FRAME_CFG       16'h8102
`define IDX_CMD             16'h8103
// field positions
`define BIT_IND_UPDATE      7
`define BIT_AUTO_DIS        7
`define BIT_SHAPE           7
`define BIT_SCROLL_LATCH    0
`define BIT_DUAL_PANEL      3
`define BIT_WS_MODE         4
// reset values
`define RST_BYTE            8'h00
`define RST_ATTR            2'h0
// cursor attribute codes
`define ATTR_OFF            2'h0
`define ATTR_STEADY         2'h1
`define ATTR_FLASH32        2'h2
`define ATTR_FLASH64        2'h3
// shift direction and command codes
`define DIR_RIGHT           2'h0
`define DIR_LEFT            2'h1
`define DIR_UP              2'h2
`define DIR_DOWN            2'h3
`define CMD_DIR_BASE        8'h4C
`define CMD_CURSOR_FORM     8'h5D
// flash duty: on for the phase steps below 70 percent of the 32 or 64 frame period
`define FLASH_ON_PCT        7'd70
`define FLASH_PCT_FULL      7'd100
// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// ---- hw/start_addr_stage.v ----
// staged 15-bit screen block start address with gated transfer to the display
`timescale 1ns/1ps
module start_addr_stage (
    mclk,
    nrst,
    wr_low,
    wr_high,
    wdata,
    scroll_latch,
    low_r,
    high_r,
    disp_addr
);
    input  wire        mclk;
    input  wire        nrst;
    input  wire        wr_low;
    input  wire        wr_high;
    input  wire [7:0]  wdata;
    input  wire        scroll_latch;
    output reg  [7:0]  low_r;
    output reg  [7:0]  high_r;
    output reg  [14:0] disp_addr;

    reg pending_r;
    wire gate_open = ~high_r[7] | scroll_latch;

    always @(posedge mclk) begin
        if (!nrst) begin
            low_r     <= 8'h00;
            high_r    <= 8'h00;
            disp_addr <= 15'h0000;
            pending_r <= 1'b0;
        end else begin
            if (wr_low)
                low_r <= wdata;
            if (wr_high) begin
                high_r <= wdata;
                if (~wdata[7] | scroll_latch) begin
                    disp_addr <= {wdata[6:0], low_r};
                    pending_r <= 1'b0;
                end else begin
                    pending_r <= 1'b1;
                end
            end else if (pending_r && gate_open) begin
                disp_addr <= {high_r[6:0], low_r};
                pending_r <= 1'b0;
            end
        end
    end
endmodule // start_addr_stage

// ---- tb/axi_host_model.sv ----
// axi4-lite host model
`timescale 1ns/1ps
module axi_host_model (
    input  wire        mclk,
    output reg  [15:0] s_axi_awaddr,
    output reg         s_axi_awvalid,
    input  wire        s_axi_awready,
    output reg  [31:0] s_axi_wdata,
    output reg  [3:0]  s_axi_wstrb,
    output reg         s_axi_wvalid,
    input  wire        s_axi_wready,
    input  wire        s_axi_bvalid,
    output reg         s_axi_bready,
    output reg  [15:0] s_axi_araddr,
    output reg         s_axi_arvalid,
    input  wire        s_axi_arready,
    input  wire        s_axi_rvalid,
    output reg         s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    end
    // ----------------------------------------
    // bus tasks, entered just after a rising edge
    // ----------------------------------------
    // byte address is index*4, cut to 16 bits
    task wr(input [15:0] idx, input [7:0] d);
        reg done;
        begin
            done = 1'b0;
            s_axi_awaddr <= idx << 2;
            s_axi_wdata <= {24'h000000, d};
            s_axi_wstrb <= 4'hF;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!done) begin
                @(posedge mclk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) done = 1'b1;
            end
        end
    endtask
    task rd(input [15:0] idx);
        reg done;
        begin
            done = 1'b0;
            s_axi_araddr <= idx << 2;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!done) begin
                @(posedge mclk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) done = 1'b1;
            end
        end
    endtask
endmodule // axi_host_model

// ---- tb/screen_block_cursor_config_bench.sv ----
// self-checking bench for the screen config block
`timescale 1ns/1ps
`include "screen_cfg_consts.vh"
module screen_block_cursor_config_bench;
    reg         mclk = 1'b0;
    reg         nrst = 1'b0;
    reg         frame_start = 1'b0;
    reg         host_mem_access = 1'b0;
    reg  [7:0]  block1_line_count = 8'h00;
    wire [15:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0]  s_axi_wstrb, cursor_width, cursor_height;
    wire [1:0]  s_axi_bresp, s_axi_rresp, cursor_attr, cursor_dir;
    wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [14:0] block2_start_addr, block3_start_addr, block4_start_addr;
    wire [7:0]  block2_line_count, block3_line_count, block4_line_count;
    wire [7:0]  block1_blank_lines, block2_blank_lines, cmd_byte, cmd_param0, cmd_param1;
    wire        cursor_shape_select, cursor_visible, cmd_valid;
    integer     miscompares = 0;
    integer     check_count = 0;
    integer     i, b, cnt, t1, t2;
    reg  [33:0] rd_q[$];
    reg  [23:0] cmd_q[$];
    reg  [23:0] ce;
    reg  [14:0] addr_exp[0:2];
    reg  [7:0]  lo, hi, frm, sl;
    always #12.5 mclk = ~mclk;
    screen_block_cursor_config dut (.*);
    axi_host_model host (.*);
    task check_val(input string what, input [33:0] exp, input [33:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task rdx(input [15:0] idx, input [1:0] resp, input [7:0] d);
        begin
            rd_q.push_back({resp, 24'h000000, d});
            host.rd(idx);
        end
    endtask
    task settle;
        repeat (4) @(posedge mclk);
    endtask
    function [15:0] lo_idx(input integer k);
        lo_idx = (k == 0) ? `IDX_B2_START_LOW : (k == 1) ? `IDX_B3_START_LOW : `IDX_B4_START_LOW;
    endfunction
    function [14:0] addr_of(input integer k);
        addr_of = (k == 0) ? block2_start_addr : (k == 1) ? block3_start_addr : block4_start_addr;
    endfunction
    // ----------------------------------------
    // result watchers: oldest note against each result
    // ----------------------------------------
    always @(posedge mclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            check_val("read", (rd_q.size() != 0) ? rd_q.pop_front() : 34'h3FFFFFFFF,
                      {s_axi_rresp, s_axi_rdata});
        if (cmd_valid === 1'b1) begin
            ce = (cmd_q.size() != 0) ? cmd_q.pop_front() : 24'hFFFFFF;
            check_val("command", ce, {cmd_byte, (ce[23:16] == `CMD_CURSOR_FORM) ?
                      {cmd_param0, cmd_param1} : ce[15:0]});
        end
    end
    initial begin
        #(25 * 30000);
        miscompares = miscompares + 1;
        $display("BAD watchdog expected finish seen hang");
        stop_test;
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        i = $urandom(32'h3B61);
        addr_exp[0] = 15'h0000;
        addr_exp[1] = 15'h0000;
        addr_exp[2] = 15'h0000;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 9; i = i + 1) rdx(`IDX_B2_START_LOW + i, `RESP_OKAY, 8'h00);
        rdx(16'h8050, `RESP_SLVERR, 8'h00);
        $display("reset done");
        for (b = 0; b < 3; b = b + 1) begin
            lo = $urandom;
            hi = $urandom % 128;
            host.wr(lo_idx(b), lo);
            settle;
            check_val("start old", addr_exp[b], addr_of(b));
            host.wr(lo_idx(b) + 1, hi);
            settle;
            addr_exp[b] = {hi[6:0], lo};
            check_val("start new", addr_exp[b], addr_of(b));
            lo = $urandom;
            hi = $urandom | 8'h80;
            host.wr(lo_idx(b), lo);
            host.wr(lo_idx(b) + 1, hi);
            settle;
            check_val("start held", addr_exp[b], addr_of(b));
            host.wr(`IDX_UNIT_CTRL, 8'h01);
            settle;
            addr_exp[b] = {hi[6:0], lo};
            check_val("start latched", addr_exp[b], addr_of(b));
            host.wr(`IDX_UNIT_CTRL, 8'h00);
            rdx(lo_idx(b) + 1, `RESP_OKAY, hi);
        end
        $display("starts done");
        for (i = 0; i < 4; i = i + 1) begin
            frm = $urandom;
            sl = $urandom;
            block1_line_count <= $urandom;
            host.wr(`IDX_FRAME_CFG, frm);
            host.wr(`IDX_B2_LINE_COUNT, sl);
            // w/s mode stays clear: no passive-matrix panel here
            host.wr(`IDX_UNIT_CTRL, {4'h0, i[0], 3'b000});
            settle;
            t1 = (frm + 1) / 2 - (block1_line_count + 1);
            t2 = (frm + 1) / 2 - (sl + 1);
            check_val("b2 lines", sl, block2_line_count);
            check_val("b3 lines", (block1_line_count < sl) ? block1_line_count : sl,
                      block3_line_count);
            check_val("b4 lines", frm, block4_line_count);
            check_val("b1 blank", (i[0] && t1 > 0) ? t1[7:0] : 8'h00, block1_blank_lines);
            check_val("b2 blank", (i[0] && t2 > 0) ? t2[7:0] : 8'h00, block2_blank_lines);
        end
        $display("lines done");
        for (i = 0; i < 2; i = i + 1) begin
            lo = 8'h80 | ($urandom % 8);
            hi = (i << 7) | ($urandom % 8);
            host.wr(`IDX_CURSOR_WIDTH, lo);
            host.wr(`IDX_CURSOR_HEIGHT, hi);
            cmd_q.push_back({`CMD_CURSOR_FORM, lo, hi});
            host.wr(`IDX_CMD, `CMD_CURSOR_FORM);
            settle;
            check_val("cursor width", lo[3:0], cursor_width);
            check_val("cursor height", hi[3:0], cursor_height);
            check_val("cursor shape", hi[7], cursor_shape_select);
        end
        for (i = 0; i < 4; i = i + 1) begin
            cmd_q.push_back({`CMD_DIR_BASE + i[7:0], 16'h0000});
            host.wr(`IDX_CMD, `CMD_DIR_BASE + i);
            settle;
            check_val("cursor dir", i[1:0], cursor_dir);
        end
        check_val("command left", 34'h0, cmd_q.size());
        $display("cursor done");
        for (i = 0; i < 4; i = i + 1) begin
            host.wr(`IDX_UNIT_STATUS, i);
            settle;
            check_val("attr", i[1:0], cursor_attr);
        end
        host.wr(`IDX_UNIT_STATUS, 8'h00);
        host_mem_access <= 1'b1;
        @(posedge mclk);
        host_mem_access <= 1'b0;
        settle;
        check_val("attr kept off", `ATTR_OFF, cursor_attr);
        host.wr(`IDX_CURSOR_WIDTH, lo & 8'h0F);
        host_mem_access <= 1'b1;
        @(posedge mclk);
        host_mem_access <= 1'b0;
        settle;
        check_val("attr auto on", `ATTR_STEADY, cursor_attr);
        rdx(`IDX_UNIT_STATUS, `RESP_OKAY, 8'h05);
        for (t2 = 2; t2 < 4; t2 = t2 + 1) begin
            host.wr(`IDX_UNIT_STATUS, t2);
            cnt = 0;
            repeat (128) begin
                frame_start <= 1'b1;
                @(posedge mclk);
                frame_start <= 1'b0;
                repeat (3) @(posedge mclk);
                cnt = cnt + (cursor_visible === 1'b1);
            end
            // about 70 of each 100 frames
            check_val("flash duty", 34'h1, (cnt >= 80 && cnt <= 100));
        end
        $display("attr done");
        stop_test;
    end
endmodule // screen_block_cursor_config_bench

// ---- tb/screen_cfg_monitor.sv ----
// port checks for the screen config block
`timescale 1ns/1ps
`include "screen_cfg_consts.vh"
module screen_cfg_monitor (
    input wire        mclk,
    input wire        nrst,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        cmd_valid,
    input wire [7:0]  block1_line_count,
    input wire [7:0]  block2_line_count,
    input wire [7:0]  block3_line_count,
    input wire [14:0] block2_start_addr,
    input wire [14:0] block3_start_addr,
    input wire [14:0] block4_start_addr,
    input wire [1:0]  cursor_attr,
    input wire        cursor_visible
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write open in resp");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar open in read");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("rdata upper set");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("cmd strobe long");
    line_min_a: assert property (($stable(block1_line_count) && $stable(block2_line_count))[*3]
        |-> block3_line_count == ((block1_line_count < block2_line_count) ?
                                  block1_line_count : block2_line_count))
        else $error("b3 count not min");
    steady_on_a: assert property ((cursor_attr == `ATTR_STEADY)[*3] |-> cursor_visible)
        else $error("steady dark");
    off_dark_a: assert property ((cursor_attr == `ATTR_OFF)[*3] |-> !cursor_visible)
        else $error("off visible");
    addr_cause_a: assert property (!$stable({block2_start_addr, block3_start_addr,
        block4_start_addr}) |-> s_axi_bvalid || $past(s_axi_bvalid)
        || $past(s_axi_bvalid, 2))
        else $error("addr moved alone");
endmodule // screen_cfg_monitor
bind screen_block_cursor_config screen_cfg_monitor mon (.*);
